// File: hw/four_channel_tone_noise_gen.v
// Function
// - Four independent channels, divisor and control each
// - Divisors at even indices d200 to d206
// - Controls at odd indices d201 to d207
// - Divider emits one pulse per N ticks
// - Low four control bits set amplitude
// - Bits seven to five select noise
// - Noise shift registers clocked at 1.79 MHz
// - Bits shift toward output, feedback enters
// - Five-bit feedback from bits three, five
// - Pass divider pulse only with noise pulse
// - Three noise counters of 4, 5, 17
// - Gating deletes whole pulses, square output
// - Six noise combinations per channel
// - Noise codes map to sources, then halve
// - Volume-only bit outputs constant level
//
// Top of the sound generator with its APB register slave.
// Assumes an APB master on pclk; audio_out feeds an external converter.
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`include "tone_noise_defs.vh"
module four_channel_tone_noise_gen #(
   parameter NUM_CH = 4                    // Channel count
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [17:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg  [5:0]  audio_out,
   output reg  [7:0]  audio_option_control,
   output reg  [7:0]  serial_keyboard_control
);
   ////////////////////////////////////////////////////////////////////////
   // Registers
   reg  [7:0]  div_q  [0:NUM_CH-1];        // Divisor per channel
   reg  [7:0]  ctl_q  [0:NUM_CH-1];        // Control per channel
   reg  [7:0]  tick_cnt_q;                 // 1.79 MHz prescaler
   reg         tick_q;                     // Noise and divider tick
   wire [3:0]  level [0:NUM_CH-1];         // Per-channel output level
   wire        p4;                         // 4-bit poly output
   wire        p5;                         // 5-bit poly output
   wire        p17;                        // 17-bit poly output
   wire        setup;                      // APB setup phase
   wire        access;                     // APB access phase
   wire [15:0] idx;                        // Register index
   wire        addr_ok;                    // Word aligned; range is checked by each hit
   wire        hit_ch;                     // Index in channel range
   wire        hit_opt;                    // Option register hit
   wire        hit_skc;                    // Serial keyboard hit
   wire        hit_stat;                   // Status register hit
   wire [7:0]  sum;                        // Sum of volumes
   wire [2:0]  ch_sel;                     // Channel selected by index
   wire        is_ctl;                     // Odd index is control

   localparam integer TICK_DIV_FULL = `POLY_TICK_DIV;      // Prescale ratio as computed
   localparam [7:0]   TICK_DIV      = TICK_DIV_FULL[7:0];  // Ratio fits eight bits at 100 MHz

   assign setup    = psel && !penable;
   assign access   = psel && penable;
   assign idx      = paddr[17:2];
   assign addr_ok  = (paddr[1:0] == 2'b00);
   assign hit_ch   = addr_ok && (idx >= `IDX_CHAN1_DIVISOR) && (idx <= `IDX_CHAN4_CONTROL);
   assign hit_opt  = addr_ok && (idx == `IDX_AUDIO_OPTION);
   assign hit_skc  = addr_ok && (idx == `IDX_SERIAL_KEYBOARD);
   assign hit_stat = (paddr == `ADDR_STATUS);
   assign ch_sel   = idx[3:1];
   assign is_ctl   = idx[0];
   assign sum      = {4'h0, level[0]} + {4'h0, level[1]} + {4'h0, level[2]} + {4'h0, level[3]};

   ////////////////////////////////////////////////////////////////////////
   // Prescaler gives a one-cycle tick near 1.79 MHz; rate is approximate
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_q <= 8'h00;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == TICK_DIV - 8'h01) begin
         tick_cnt_q <= 8'h00;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 8'h01;
         tick_q     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Three free-running noise counters
   poly_counter #(.LEN(4),  .TAP_A(2),  .TAP_B(3),  .SEED(`RST_POLY4)) u_poly4 (
      .pclk    (pclk),
      .presetn (presetn),
      .advance (tick_q),
      .bit_out (p4)
   );
   poly_counter #(.LEN(5),  .TAP_A(2),  .TAP_B(4),  .SEED(`RST_POLY5)) u_poly5 (
      .pclk    (pclk),
      .presetn (presetn),
      .advance (tick_q),
      .bit_out (p5)
   );
   poly_counter #(.LEN(17), .TAP_A(11), .TAP_B(16), .SEED(`RST_POLY17)) u_poly17 (
      .pclk    (pclk),
      .presetn (presetn),
      .advance (tick_q),
      .bit_out (p17)
   );

   ////////////////////////////////////////////////////////////////////////
   // Per-channel registers and generators
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
         // Register writes land on the access edge with lane 0 strobed
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               div_q[g] <= `RST_DIVISOR;
               ctl_q[g] <= `RST_CONTROL;
            end else if (access && pwrite && hit_ch && pstrb[0] && (ch_sel == g)) begin
               if (is_ctl) begin
                  ctl_q[g] <= pwdata[7:0];
               end else begin
                  div_q[g] <= pwdata[7:0];
               end
            end
         end
         tone_channel u_chan (
            .pclk    (pclk),
            .presetn (presetn),
            .tick    (tick_q),
            .divisor (div_q[g]),
            .control (ctl_q[g]),
            .p4      (p4),
            .p5      (p5),
            .p17     (p17),
            .level_q (level[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Option and serial registers: stored only, their effects lie elsewhere
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         audio_option_control    <= `RST_OPTION;
         serial_keyboard_control <= `RST_SERIAL_KB;
      end else if (access && pwrite && pstrb[0]) begin
         if (hit_opt) begin
            audio_option_control <= pwdata[7:0];
         end
         if (hit_skc) begin
            serial_keyboard_control <= pwdata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB answer: no wait state, ready raised in the first access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (setup) begin
         pready  <= 1'b1;
         // Write-only registers refuse reads; unmapped refuses both
         pslverr <= pwrite ? !(hit_ch || hit_opt || hit_skc) : !hit_stat;
         prdata  <= hit_stat && !pwrite ? {24'h000000, sum} : 32'h0000_0000;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Summed audio, six bits hold every total up to the maximum of 60
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         audio_out <= 6'h00;
      end else begin
         audio_out <= sum[5:0];
      end
   end
endmodule // four_channel_tone_noise_gen

// File: hw/poly_counter.v
// Polynomial noise shift register of parameterised length with two feedback taps.
// Assumes a one-cycle advance strobe from the owner; shifts toward the high end.
`timescale 1ns/10ps
module poly_counter #(
   parameter LEN   = 5,                    // Register length
   parameter TAP_A = 2,                    // First feedback tap (0-based)
   parameter TAP_B = 4,                    // Second tap, also the output end
   parameter [LEN-1:0] SEED = {LEN{1'b1}}  // Non-zero seed, XOR feedback locks only on all zeros
) (
   input  wire pclk,
   input  wire presetn,
   input  wire advance,
   output wire bit_out
);
   reg [LEN-1:0] sr_q;                     // Shift register contents
   wire          fb;                       // Feedback into bit 0

   // XOR of two taps, all-ones seed keeps the sequence non-degenerate
   assign fb      = sr_q[TAP_A] ^ sr_q[TAP_B];
   assign bit_out = sr_q[LEN-1];           // Last bit is output

   ////////////////////////////////////////////////////////////////////////
   // Shift one place toward the output on each advance
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sr_q <= SEED;
      end else if (advance) begin
         sr_q <= {sr_q[LEN-2:0], fb};
      end
   end
endmodule // poly_counter

// File: hw/tone_channel.v
// One sound channel: divide-by-N, noise selection, divide by two, volume gating.
// Assumes poly bits and one-cycle input tick from the owner.
`timescale 1ns/10ps
`include "tone_noise_defs.vh"
module tone_channel (
   input  wire       pclk,
   input  wire       presetn,
   input  wire       tick,
   input  wire [7:0] divisor,
   input  wire [7:0] control,
   input  wire       p4,
   input  wire       p5,
   input  wire       p17,
   output reg  [3:0] level_q
);
   reg  [7:0] cnt_q;                       // Divide-by-N counter
   reg        sq_q;                        // Square output after divide by two
   reg        pass;                        // Selection result
   wire       div_pulse;                   // One pulse each N ticks
   wire [2:0] noise;                       // Noise-select field

   assign noise     = control[`CTL_NOISE_MSB:`CTL_NOISE_LSB];
   assign div_pulse = tick && (cnt_q == 8'h00);

   ////////////////////////////////////////////////////////////////////////
   // Selection: six combinations; 5-bit then another means both must be high
   always @* begin
      pass = 1'b1;
      casez (noise)
         3'b000:  pass = p5 & p17;
         3'b0?1:  pass = p5;
         3'b010:  pass = p5 & p4;
         3'b100:  pass = p17;
         3'b1?1:  pass = 1'b1;              // Pure tone
         3'b110:  pass = p4;
         default: pass = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Divider counts N ticks, zero divisor treated as divide by one
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q   <= 8'h00;
         sq_q    <= 1'b0;
         level_q <= 4'h0;
      end else begin
         if (tick) begin
            if (cnt_q == 8'h00) begin
               cnt_q <= (divisor == 8'h00) ? 8'h00 : divisor - 8'h01;
            end else begin
               cnt_q <= cnt_q - 8'h01;
            end
         end
         // Only whole pulses are dropped, so output stays square
         if (div_pulse && pass) begin
            sq_q <= ~sq_q;
         end
         // Volume-only bypasses the waveform entirely
         if (control[`CTL_VOL_ONLY]) begin
            level_q <= control[`CTL_VOL_MSB:`CTL_VOL_LSB];
         end else begin
            level_q <= sq_q ? control[`CTL_VOL_MSB:`CTL_VOL_LSB] : 4'h0;
         end
      end
   end
endmodule // tone_channel

// File: hw/tone_noise_defs.vh
// Register offsets, field positions, reset values and timing counts for the tone/noise generator.
// Assumes inclusion by bare name from each design file.
`ifndef TONE_NOISE_DEFS_VH
`define TONE_NOISE_DEFS_VH
// Register indices of the channel, option and serial keyboard registers (printed offsets are not all multiples of four, so byte address is index*4)
`define IDX_CHAN1_DIVISOR     16'hd200
`define IDX_CHAN1_CONTROL     16'hd201
`define IDX_CHAN2_DIVISOR     16'hd202
`define IDX_CHAN2_CONTROL     16'hd203
`define IDX_CHAN3_DIVISOR     16'hd204
`define IDX_CHAN3_CONTROL     16'hd205
`define IDX_CHAN4_DIVISOR     16'hd206
`define IDX_CHAN4_CONTROL     16'hd207
`define IDX_AUDIO_OPTION      16'hd208
`define IDX_SERIAL_KEYBOARD   16'hd20f
// Byte address of the status register of own choosing
`define ADDR_STATUS           18'h00100
// Control register fields
`define CTL_VOL_LSB           0
`define CTL_VOL_MSB           3
`define CTL_VOL_ONLY          4
`define CTL_NOISE_LSB         5
`define CTL_NOISE_MSB         7
// Reset values
`define RST_DIVISOR           8'h00
`define RST_CONTROL           8'h00
`define RST_OPTION            8'h00
`define RST_SERIAL_KB         8'h00
`define RST_POLY4             4'hf
`define RST_POLY5             5'h1f
`define RST_POLY17            17'h1ffff
// Noise tick: 1.79 MHz derived from 100 MHz clock
`define POLY_TICK_KHZ         1790
`define CLK_KHZ               100000
`define POLY_TICK_DIV         ((`CLK_KHZ) / (`POLY_TICK_KHZ))
`endif

// File: verification/audio_sink.sv
// Model of the audio stage: times rises of the summed output out of silence.
// Assumes audio_out is registered on pclk.
`timescale 1ns/10ps
module audio_sink (
   input  wire        pclk,
   input  wire        presetn,
   input  wire [5:0]  audio_out,
   output reg  [15:0] period_q,
   output reg  [15:0] rises_q
);
   reg [15:0] cnt_q;   // Cycles since last rise
   reg        zero_q;  // Previous sample was silent
   // Rise detector; only a rise from zero counts, so level steps are ignored
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q    <= 16'h0000;
         zero_q   <= 1'b1;
         period_q <= 16'h0000;
         rises_q  <= 16'h0000;
      end else begin
         zero_q <= (audio_out == 6'h00);
         cnt_q  <= cnt_q + 16'h0001;
         if (zero_q && (audio_out != 6'h00)) begin // New pulse
            period_q <= cnt_q;
            rises_q  <= rises_q + 16'h0001;
            cnt_q    <= 16'h0001;
         end
      end
   end
endmodule // audio_sink

// File: verification/four_channel_tone_noise_gen_sva.sv
// Port checker for the tone/noise generator top.
// Assumes one pclk domain, presetn asynchronous active low.
`timescale 1ns/10ps
module tone_noise_gen_sva (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [17:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0]  pstrb,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire [5:0]  audio_out,
   input wire [7:0]  audio_option_control,
   input wire [7:0]  serial_keyboard_control
);
   wire chan_a = (paddr >= 18'h34800) && (paddr <= 18'h3481c) && (paddr[1:0] == 2'b00); // Channel slots
   wire opt_a  = (paddr == 18'h34820);  // Option register
   wire skc_a  = (paddr == 18'h3483c);  // Serial/keyboard register
   wire wr_acc = psel & penable & pready & pwrite & pstrb[0]; // Landing write
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////
   sequence s_setup; psel && !penable; endsequence
   sequence s_answer; pready ##1 !pready; endsequence
   property p_answer; s_setup |=> s_answer; endproperty
   property p_wr_err; pready && pwrite && !(chan_a || opt_a || skc_a) |-> pslverr; endproperty
   property p_wr_ok; pready && pwrite && chan_a |-> !pslverr; endproperty
   property p_rd_err; pready && !pwrite && (paddr != 18'h00100) |-> pslverr && (prdata == 32'h0); endproperty
   property p_status;
      pready && !pwrite && (paddr == 18'h00100) |-> !pslverr && (prdata == {26'h0, audio_out});
   endproperty
   property p_opt; wr_acc && opt_a |=> audio_option_control == $past(pwdata[7:0]); endproperty
   property p_skc; wr_acc && skc_a |=> serial_keyboard_control == $past(pwdata[7:0]); endproperty
   property p_opt_hold; !(wr_acc && opt_a) |=> $stable(audio_option_control); endproperty
   property p_max; audio_out <= 6'd60; endproperty
   a_answer: assert property (p_answer) else $error("no single answer cycle");
   a_wr_err: assert property (p_wr_err) else $error("bad write not refused");
   a_wr_ok: assert property (p_wr_ok) else $error("channel write refused");
   a_rd_err: assert property (p_rd_err) else $error("bad read not refused");
   a_status: assert property (p_status) else $error("status read wrong");
   a_opt: assert property (p_opt) else $error("option not stored");
   a_skc: assert property (p_skc) else $error("serial control not stored");
   a_opt_hold: assert property (p_opt_hold) else $error("option changed alone");
   a_max: assert property (p_max) else $error("audio sum too large");
endmodule // tone_noise_gen_sva
bind four_channel_tone_noise_gen tone_noise_gen_sva tone_noise_gen_sva_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .audio_out(audio_out),
   .audio_option_control(audio_option_control), .serial_keyboard_control(serial_keyboard_control));

// File: verification/four_channel_tone_noise_gen_tb_top.sv
// Testbench: APB register tasks and scenario calls for the tone/noise generator.
// Assumes audio_sink model and bound checker are compiled beforehand.
`timescale 1ns/10ps
`include "tone_noise_defs.vh"
module four_channel_tone_noise_gen_tb_top;
   reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg  [17:0] paddr = 18'h0;
   reg  [31:0] pwdata = 32'h0;
   reg  [3:0]  pstrb = 4'h0;
   wire [31:0] prdata;
   wire        pready, pslverr;
   wire [5:0]  audio_out;
   wire [7:0]  audio_option_control, serial_keyboard_control;
   wire [15:0] period_q, rises_q;
   integer     err_total = 0, samples_checked = 0, i, k;
   reg  [31:0] rd;     // Read data taken
   reg         er;     // Error flag taken
   reg  [15:0] r0;     // Rise count snapshot
   always #5 pclk = ~pclk;
   four_channel_tone_noise_gen four_channel_tone_noise_gen_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .audio_out(audio_out), .audio_option_control(audio_option_control),
      .serial_keyboard_control(serial_keyboard_control));
   audio_sink audio_sink_inst (.pclk(pclk), .presetn(presetn), .audio_out(audio_out), .period_q(period_q),
      .rises_q(rises_q));
   ////////////////////////////////////////////////////////////////////////
   // Compare and count
   task check(input [31:0] seen, input [31:0] want);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== want) begin
            err_total = err_total + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
         end
      end
   endtask
   // One APB transfer; waits for pready under a bound rather than assuming latency
   task apb(input w, input [17:0] a, input [7:0] d, input [3:0] s);
      integer n;
      begin
         @(posedge pclk);
         psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d}; pstrb <= s;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         @(posedge pclk);
         while (pready !== 1'b1 && n < 20) begin
            n = n + 1;
            @(posedge pclk);
         end
         if (n == 20) check(32'h0, 32'h1);
         rd = prdata;
         er = pslverr;
         psel <= 1'b0; penable <= 1'b0;
      end
   endtask
   function [17:0] ba(input [15:0] idx); ba = {idx, 2'b00}; endfunction
   task wr(input [15:0] idx, input [7:0] d); apb(1'b1, ba(idx), d, 4'h1); endtask
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", samples_checked, err_total);
         if (err_total == 0 && samples_checked > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Watchdog, well past the roughly 29000 cycles of the tests
   initial begin
      #700000;
      err_total = err_total + 1;
      tally_and_finish;
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check({24'h0, serial_keyboard_control}, 32'h0);
      wr(`IDX_AUDIO_OPTION, 8'h00);
      wr(`IDX_SERIAL_KEYBOARD, 8'h03);
      @(posedge pclk);
      check({16'h0, audio_option_control, serial_keyboard_control}, 32'h0003);
      apb(1'b1, ba(`IDX_SERIAL_KEYBOARD), 8'h55, 4'he); // Lane 0 off: no effect
      check({31'h0, er}, 32'h0);
      apb(1'b1, ba(`IDX_SERIAL_KEYBOARD) + 18'h1, 8'h55, 4'h1); // Unaligned: refused
      check({31'h0, er}, 32'h1);
      check({24'h0, serial_keyboard_control}, 32'h3);
      // Serial use leaves other settings behind; software then repeats the setup
      wr(`IDX_AUDIO_OPTION, 8'h5a);
      wr(`IDX_SERIAL_KEYBOARD, 8'h13);
      @(posedge pclk);
      check({16'h0, audio_option_control, serial_keyboard_control}, 32'h5a13);
      wr(`IDX_AUDIO_OPTION, 8'h00);
      wr(`IDX_SERIAL_KEYBOARD, 8'h03);
      @(posedge pclk);
      check({16'h0, audio_option_control, serial_keyboard_control}, 32'h0003);
      apb(1'b0, ba(`IDX_CHAN1_CONTROL), 8'h00, 4'h0); // Write-only place
      check({rd[30:0], er}, 32'h1);
      for (i = 0; i < 4; i = i + 1) wr(`IDX_CHAN1_CONTROL + 2 * i, 8'h18); // Volume-only 8 each
      repeat (4) @(posedge pclk);
      check({26'h0, audio_out}, 32'd32);
      apb(1'b0, 18'h00100, 8'h00, 4'h0);
      check({rd[30:0], er}, {31'd32, 1'b0});
      r0 = rises_q;
      repeat (300) @(posedge pclk);
      check({rises_q, 10'h0, audio_out}, {r0, 16'd32});
      for (i = 0; i < 4; i = i + 1) wr(`IDX_CHAN1_CONTROL + 2 * i, 8'h10);
      repeat (4) @(posedge pclk);
      check({26'h0, audio_out}, 32'h0);
      wr(`IDX_CHAN2_DIVISOR, 8'h03);
      wr(`IDX_CHAN2_CONTROL, 8'ha5); // Pure tone, volume 5
      repeat (1400) @(posedge pclk);
      check({16'h0, period_q}, 2 * 3 * `POLY_TICK_DIV);
      wr(`IDX_CHAN2_DIVISOR, 8'h07);
      repeat (3200) @(posedge pclk);
      check({16'h0, period_q}, 2 * 7 * `POLY_TICK_DIV);
      wr(`IDX_CHAN2_DIVISOR, 8'h01);
      for (k = 0; k < 8; k = k + 1) begin // Every noise code, X bits both ways
         wr(`IDX_CHAN2_CONTROL, {k[2:0], 5'h04});
         repeat (4) @(posedge pclk);
         r0 = rises_q;
         repeat (3000) begin
            @(posedge pclk);
            check({31'h0, audio_out == 6'd0 || audio_out == 6'd4}, 32'h1);
         end
         check({31'h0, rises_q != r0}, 32'h1);
         // Pure tone gives at least 27 rises in 3000 cycles; any poly source drops some
         check({31'h0, (rises_q - r0) >= 16'd27}, {31'h0, k[2] & k[0]});
      end
      tally_and_finish;
   end
endmodule // four_channel_tone_noise_gen_tb_top
